// [core/rbt_consts.svh]
// Constants for the registered bus transceiver
// Assumes inclusion by the package and the core module only
`ifndef RBT_CONSTS_SVH
`define RBT_CONSTS_SVH
`define RBT_SECT_W    8
`define RBT_NUM_SECT  2
`define RBT_SYNC_LEN  3
`endif

// [core/rbt_pkg.sv]
// Types for the registered bus transceiver
// Assumes rbt_consts.svh is on the include path
`include "rbt_consts.svh"
package rbt_pkg;
	typedef logic [`RBT_SECT_W-1:0] rbt_byte_t;

	// Control pins of one section
	typedef struct packed {
		logic oe_n;
		logic dir;
		logic a_to_b_capture_clock;
		logic b_to_a_capture_clock;
		logic a_to_b_source_select;
		logic b_to_a_source_select;
	} rbt_ctrl_t;

	// Three-stage synchroniser chain for the control pins
	typedef struct packed {
		rbt_ctrl_t s3;
		rbt_ctrl_t s2;
		rbt_ctrl_t s1;
	} rbt_csync_t;

	typedef struct packed {
		rbt_byte_t s3;
		rbt_byte_t s2;
		rbt_byte_t s1;
	} rbt_dsync_t;

	// Whole state of one section
	typedef struct packed {
		rbt_csync_t cs;
		rbt_dsync_t as;
		rbt_dsync_t bs;
		rbt_ctrl_t  ctl;
		rbt_byte_t  a_reg;
		rbt_byte_t  b_reg;
		rbt_byte_t  a_out;
		rbt_byte_t  b_out;
		logic       a_oe;
		logic       b_oe;
	} rbt_sect_t;
endpackage

// [core/rbt_core.sv]
// Registered 16-bit bus transceiver built as two 8-bit sections
// Assumes all pins asynchronous to clk_i; bus wires resolved outside
// Assumes each section's enables gate its own bus drivers outside
// Notes on behaviour
// [R1] 16-bit path, tri-state drivers, storage registers
// [R2] Capture clock rising edges latch each bus
// [R3] Capture ignores enable and direction
// [R4] Enable high: neither bus driven
// [R5] Input bus storable while transmitting
// [R6] Direction low drives A, high drives B
// [R7] Live B onto A
// [R8] Stored B register onto A
// [R9] Live A onto B
// [R10] Stored A register onto B
// [R11] Never drive both buses together
// [R12] A feeds A register, B feeds B register
// [R13] Two independent 8-bit sections
`timescale 1ns/100ps
`include "rbt_consts.svh"
module rbt_core
	import rbt_pkg::*;
#(
	parameter int SECT_W   = `RBT_SECT_W,
	parameter int NUM_SECT = `RBT_NUM_SECT
) (
	input  wire logic                     clk_i,
	input  wire logic                     rst_i,
	input  wire rbt_ctrl_t [NUM_SECT-1:0] ctrl_i,
	input  wire logic [NUM_SECT*SECT_W-1:0] a_i,
	output logic      [NUM_SECT*SECT_W-1:0] a_o,
	output logic      [NUM_SECT-1:0]       a_oe_o,
	input  wire logic [NUM_SECT*SECT_W-1:0] b_i,
	output logic      [NUM_SECT*SECT_W-1:0] b_o,
	output logic      [NUM_SECT-1:0]       b_oe_o
);
	// ********************
	// Section state
	// ********************
	rbt_sect_t sect_q [NUM_SECT];
	rbt_sect_t sect_d [NUM_SECT];

	// ********************
	// Helper functions
	// ********************
	// Change counts once the second and third stages agree
	function automatic logic agree(input logic s2, input logic s3, input logic old);
		agree = (s2 == s3) ? s3 : old;
	endfunction

	// Low-to-high step of a filtered control level
	function automatic logic rise(input logic now, input logic old);
		rise = now & ~old;
	endfunction

	// Stored register when the select is high, live bus when low
	function automatic rbt_byte_t pick(input logic sel, input rbt_byte_t stored,
		input rbt_byte_t live);
		pick = sel ? stored : live;
	endfunction

	for (genvar g = 0; g < NUM_SECT; g++) begin : g_sect // [R13]
		// ********************
		// Next state of one section
		// ********************
		always_comb begin
			rbt_sect_t n;
			logic      ab_rise;
			logic      ba_rise;
			n       = sect_q[g];
			ab_rise = 1'h0;
			ba_rise = 1'h0;
			// Every pin passes three flops, data and control alike
			n.cs.s1 = ctrl_i[g];
			n.cs.s2 = sect_q[g].cs.s1;
			n.cs.s3 = sect_q[g].cs.s2;
			n.as.s1 = a_i[g*SECT_W +: SECT_W];
			n.as.s2 = sect_q[g].as.s1;
			n.as.s3 = sect_q[g].as.s2;
			n.bs.s1 = b_i[g*SECT_W +: SECT_W];
			n.bs.s2 = sect_q[g].bs.s1;
			n.bs.s3 = sect_q[g].bs.s2;
			// Filtered control levels
			n.ctl.oe_n = agree(sect_q[g].cs.s2.oe_n, sect_q[g].cs.s3.oe_n,
				sect_q[g].ctl.oe_n);
			n.ctl.dir = agree(sect_q[g].cs.s2.dir, sect_q[g].cs.s3.dir,
				sect_q[g].ctl.dir);
			n.ctl.a_to_b_capture_clock = agree(sect_q[g].cs.s2.a_to_b_capture_clock,
				sect_q[g].cs.s3.a_to_b_capture_clock, sect_q[g].ctl.a_to_b_capture_clock);
			n.ctl.b_to_a_capture_clock = agree(sect_q[g].cs.s2.b_to_a_capture_clock,
				sect_q[g].cs.s3.b_to_a_capture_clock, sect_q[g].ctl.b_to_a_capture_clock);
			n.ctl.a_to_b_source_select = agree(sect_q[g].cs.s2.a_to_b_source_select,
				sect_q[g].cs.s3.a_to_b_source_select, sect_q[g].ctl.a_to_b_source_select);
			n.ctl.b_to_a_source_select = agree(sect_q[g].cs.s2.b_to_a_source_select,
				sect_q[g].cs.s3.b_to_a_source_select, sect_q[g].ctl.b_to_a_source_select);
			// Capture on filtered rising edge, no gating by enable [R2] [R3] [R5]
			ab_rise = rise(n.ctl.a_to_b_capture_clock,
				sect_q[g].ctl.a_to_b_capture_clock);
			ba_rise = rise(n.ctl.b_to_a_capture_clock,
				sect_q[g].ctl.b_to_a_capture_clock);
			if (ab_rise) begin
				n.a_reg = sect_q[g].as.s3; // [R12]
			end
			if (ba_rise) begin
				n.b_reg = sect_q[g].bs.s3; // [R12]
			end
			// Output drivers from filtered controls [R4] [R6] [R11]
			n.a_oe = ~n.ctl.oe_n & ~n.ctl.dir;
			n.b_oe = ~n.ctl.oe_n & n.ctl.dir;
			// Live or stored data; the registered path adds a fixed latency [R7] [R8]
			n.a_out = pick(n.ctl.b_to_a_source_select, n.b_reg, sect_q[g].bs.s3);
			// [R9] [R10]
			n.b_out = pick(n.ctl.a_to_b_source_select, n.a_reg, sect_q[g].as.s3);
			sect_d[g] = n;
		end

		// ********************
		// State register
		// ********************
		// Control pin stages and filtered levels reset high: drivers stay off
		// and no capture edge can be seen as reset lets go
		always_ff @(posedge clk_i or posedge rst_i) begin
			if (rst_i) begin
				sect_q[g]     <= '0;
				sect_q[g].cs  <= '1;
				sect_q[g].ctl <= '1;
			end else begin
				sect_q[g] <= sect_d[g];
			end
		end

		// ********************
		// Output ports
		// ********************
		assign a_o[g*SECT_W +: SECT_W] = sect_q[g].a_out; // [R1]
		assign b_o[g*SECT_W +: SECT_W] = sect_q[g].b_out;
		assign a_oe_o[g] = sect_q[g].a_oe;
		assign b_oe_o[g] = sect_q[g].b_oe;

		// ********************
		// Assertions
		// ********************
		AST_NO_BOTH: assert property (@(posedge clk_i) disable iff (rst_i) // [R11]
			!(a_oe_o[g] && b_oe_o[g]))
			else $error("both buses driven");
		// Enables follow settled pin levels one edge later
		AST_ISOLATE: assert property (@(posedge clk_i) disable iff (rst_i) // [R4]
			(sect_q[g].cs.s2.oe_n && sect_q[g].cs.s3.oe_n)
			|=> !a_oe_o[g] && !b_oe_o[g])
			else $error("driver on while disabled");
		AST_DIR_A: assert property (@(posedge clk_i) disable iff (rst_i) // [R6]
			(!sect_q[g].cs.s2.oe_n && !sect_q[g].cs.s3.oe_n
			&& !sect_q[g].cs.s2.dir && !sect_q[g].cs.s3.dir) |=> a_oe_o[g])
			else $error("A not driven");
		AST_DIR_B: assert property (@(posedge clk_i) disable iff (rst_i) // [R6]
			(!sect_q[g].cs.s2.oe_n && !sect_q[g].cs.s3.oe_n
			&& sect_q[g].cs.s2.dir && sect_q[g].cs.s3.dir) |=> b_oe_o[g])
			else $error("B not driven");
		AST_CAP_A: assert property (@(posedge clk_i) disable iff (rst_i) // [R2]
			(sect_d[g].ctl.a_to_b_capture_clock && !sect_q[g].ctl.a_to_b_capture_clock)
			|=> sect_q[g].a_reg == $past(sect_q[g].as.s3))
			else $error("A register missed capture");
		AST_CAP_B: assert property (@(posedge clk_i) disable iff (rst_i) // [R3]
			(sect_d[g].ctl.b_to_a_capture_clock && !sect_q[g].ctl.b_to_a_capture_clock)
			|=> sect_q[g].b_reg == $past(sect_q[g].bs.s3))
			else $error("B register missed capture");
		AST_HOLD_A: assert property (@(posedge clk_i) disable iff (rst_i) // [R2]
			!(sect_d[g].ctl.a_to_b_capture_clock && !sect_q[g].ctl.a_to_b_capture_clock)
			|=> $stable(sect_q[g].a_reg))
			else $error("A register changed without edge");
		AST_HOLD_B: assert property (@(posedge clk_i) disable iff (rst_i) // [R2]
			!(sect_d[g].ctl.b_to_a_capture_clock && !sect_q[g].ctl.b_to_a_capture_clock)
			|=> $stable(sect_q[g].b_reg))
			else $error("B register changed without edge");
		// A pin level is held until two synchroniser stages agree
		AST_FILTER_AB: assert property (@(posedge clk_i) disable iff (rst_i) // [R2]
			(sect_q[g].cs.s2.a_to_b_capture_clock
			!= sect_q[g].cs.s3.a_to_b_capture_clock)
			|=> $stable(sect_q[g].ctl.a_to_b_capture_clock))
			else $error("A capture level taken too early");
		AST_FILTER_BA: assert property (@(posedge clk_i) disable iff (rst_i) // [R2]
			(sect_q[g].cs.s2.b_to_a_capture_clock
			!= sect_q[g].cs.s3.b_to_a_capture_clock)
			|=> $stable(sect_q[g].ctl.b_to_a_capture_clock))
			else $error("B capture level taken too early");
		AST_FILTER_OE: assert property (@(posedge clk_i) disable iff (rst_i) // [R4]
			(sect_q[g].cs.s2.oe_n != sect_q[g].cs.s3.oe_n)
			|=> $stable(sect_q[g].ctl.oe_n))
			else $error("enable level taken too early");
		AST_FILTER_DIR: assert property (@(posedge clk_i) disable iff (rst_i) // [R6]
			(sect_q[g].cs.s2.dir != sect_q[g].cs.s3.dir)
			|=> $stable(sect_q[g].ctl.dir))
			else $error("direction level taken too early");
		// Data path to each bus
		AST_LIVE_B2A: assert property (@(posedge clk_i) disable iff (rst_i) // [R7]
			!sect_d[g].ctl.b_to_a_source_select |=> a_o[g*SECT_W +: SECT_W]
			== $past(sect_q[g].bs.s3))
			else $error("live B not on A");
		AST_STORED_B2A: assert property (@(posedge clk_i) disable iff (rst_i) // [R8]
			sect_d[g].ctl.b_to_a_source_select |=> a_o[g*SECT_W +: SECT_W]
			== sect_q[g].b_reg)
			else $error("stored B not on A");
		AST_LIVE_A2B: assert property (@(posedge clk_i) disable iff (rst_i) // [R9]
			!sect_d[g].ctl.a_to_b_source_select |=> b_o[g*SECT_W +: SECT_W]
			== $past(sect_q[g].as.s3))
			else $error("live A not on B");
		AST_STORED_A2B: assert property (@(posedge clk_i) disable iff (rst_i) // [R10]
			sect_d[g].ctl.a_to_b_source_select |=> b_o[g*SECT_W +: SECT_W]
			== sect_q[g].a_reg)
			else $error("stored A not on B");

		// ********************
		// Cover points
		// ********************
		// Main transfers of one section
		COV_DRIVE_A: cover property (@(posedge clk_i) disable iff (rst_i) a_oe_o[g]);
		COV_DRIVE_B: cover property (@(posedge clk_i) disable iff (rst_i) b_oe_o[g]);
		COV_CAP_ISO: cover property (@(posedge clk_i) disable iff (rst_i)
			sect_q[g].ctl.oe_n && sect_d[g].ctl.a_to_b_capture_clock
			&& !sect_q[g].ctl.a_to_b_capture_clock);
		COV_LIVE_B2A: cover property (@(posedge clk_i) disable iff (rst_i)
			a_oe_o[g] && !sect_q[g].ctl.b_to_a_source_select);
		COV_STORED_A2B: cover property (@(posedge clk_i) disable iff (rst_i)
			b_oe_o[g] && sect_q[g].ctl.a_to_b_source_select);
	end
endmodule

// [bench/rbt_bus_model.sv]
// Far-side logic on the A and B buses of the transceiver
// Assumes one-byte sections and enable high while the device drives
`timescale 1ns/100ps
module rbt_bus_model (
	input  wire logic [15:0] dev_a_i,
	input  wire logic [1:0]  dev_a_oe_i,
	input  wire logic [15:0] dev_b_i,
	input  wire logic [1:0]  dev_b_oe_i,
	input  wire logic [15:0] drv_a_i,
	input  wire logic [15:0] drv_b_i,
	output logic      [15:0] a_o,
	output logic      [15:0] b_o
);
	// Far side lets go of a byte lane while the device drives it
	always_comb begin
		for (int s = 0; s < 2; s++) begin
			a_o[s*8 +: 8] = dev_a_oe_i[s] ? dev_a_i[s*8 +: 8] : drv_a_i[s*8 +: 8];
			b_o[s*8 +: 8] = dev_b_oe_i[s] ? dev_b_i[s*8 +: 8] : drv_b_i[s*8 +: 8];
		end
	end
endmodule

// [bench/tb_rbt_core.sv]
// Self-checking bench for the registered bus transceiver
// Assumes rbt_pkg compiled first and rbt_bus_model on the far side
`timescale 1ns/100ps
module tb_rbt_core
	import rbt_pkg::*;
;
	logic             clk;
	logic             rst;
	rbt_ctrl_t [1:0]  ctrl;
	logic      [15:0] a_bus, b_bus, a_o, b_o, drv_a, drv_b;
	logic      [1:0]  a_oe, b_oe;
	int               num_errors = 0;
	int               check_count = 0;

	rbt_core uut (.clk_i(clk), .rst_i(rst), .ctrl_i(ctrl), .a_i(a_bus), .a_o(a_o),
		.a_oe_o(a_oe), .b_i(b_bus), .b_o(b_o), .b_oe_o(b_oe));
	rbt_bus_model bus (.dev_a_i(a_o), .dev_a_oe_i(a_oe), .dev_b_i(b_o), .dev_b_oe_i(b_oe),
		.drv_a_i(drv_a), .drv_b_i(drv_b), .a_o(a_bus), .b_o(b_bus));

	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		check_count++;
		if (seen !== exp) begin
			num_errors++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	// Control bits: oe_n, dir, capture a-b, capture b-a, select a-b, select b-a
	task automatic step(input logic [5:0] c1, input logic [5:0] c0,
		input logic [15:0] a, input logic [15:0] b);
		@(negedge clk);
		ctrl = {c1, c0};
		drv_a = a;
		drv_b = b;
		repeat (8) @(negedge clk);
	endtask

	task automatic complete_run;
		$display("checks %0d mismatches %0d", check_count, num_errors);
		if (num_errors == 0 && check_count > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	initial begin
		repeat (1000) @(posedge clk);
		num_errors++;
		complete_run;
	end

	initial begin
		rst = 1'b1;
		ctrl = 12'h820;
		drv_a = 16'h0000;
		drv_b = 16'h0000;
		repeat (16) @(negedge clk);
		rst = 1'b0;
		// Isolation, then capture both buses while isolated
		step(6'h20, 6'h20, 16'hA55A, 16'h3CC3);
		chk(16'(a_oe), 16'h0000);
		chk(16'(b_oe), 16'h0000);
		step(6'h2C, 6'h2C, 16'hA55A, 16'h3CC3);
		step(6'h20, 6'h20, 16'hA55A, 16'h3CC3);
		$display("test isolation done");
		// Stored data out, sections pointed opposite ways
		step(6'h12, 6'h01, 16'h1111, 16'h2222);
		chk(16'(b_oe), 16'h0002);
		chk(16'(a_oe), 16'h0001);
		chk(16'(b_o[15:8]), 16'h00A5);
		chk(16'(a_o[7:0]), 16'h00C3);
		// Live data through
		step(6'h10, 6'h00, 16'h6996, 16'h7EE7);
		chk(16'(b_o[15:8]), 16'h0069);
		chk(16'(a_o[7:0]), 16'h00E7);
		$display("test stored and live done");
		// Capture the input bus while transmitting
		step(6'h1A, 6'h04, 16'h6996, 16'h7EE7);
		step(6'h12, 6'h01, 16'h1111, 16'h2222);
		chk(16'(b_o[15:8]), 16'h0069);
		chk(16'(a_o[7:0]), 16'h00E7);
		// Full width in each direction
		step(6'h12, 6'h12, 16'h1111, 16'h2222);
		chk(16'(b_oe), 16'h0003);
		chk(16'(a_oe), 16'h0000);
		chk(b_o, 16'h695A);
		step(6'h01, 6'h01, 16'h1111, 16'h2222);
		chk(a_o, 16'h3CE7);
		chk(16'(b_oe), 16'h0000);
		$display("test capture while driving done");
		// Reset in mid-run empties the A storage register of both sections
		@(negedge clk);
		rst = 1'b1;
		@(negedge clk);
		rst = 1'b0;
		step(6'h12, 6'h12, 16'h1111, 16'h2222);
		chk(b_o, 16'h0000);
		chk(16'(b_oe), 16'h0003);
		$display("test reset done");
		complete_run;
	end
endmodule
